// >>> hdl/rot_pkg.sv
// Shared constants and types for the prefixed rotate unit
package rot_pkg;
  // ****************************************
  // Instruction bytes
  // ****************************************
  localparam logic [7:0] OPC_PREFIX_BIT = 8'hcb;  // Bit-group prefix
  localparam logic [7:0] OPC_PREFIX_X1 = 8'hdd;   // First index register prefix
  localparam logic [7:0] OPC_PREFIX_X2 = 8'hfd;   // Second index register prefix
  localparam logic [7:0] OPC_ROT_LC = 8'h06;      // Memory form, left circular
  localparam logic [7:0] OPC_ROT_RC = 8'h0e;      // Memory form, right circular
  localparam logic [7:0] OPC_ROT_LT = 8'h16;      // Memory form, left through carry
  localparam logic [7:0] OPC_ROT_RT = 8'h1e;      // Memory form, right through carry
  localparam logic [2:0] SEL_MEM = 3'h6;          // Selector code for a memory operand
  localparam logic [2:0] SEL_H = 3'h4;            // Pointer pair high register
  localparam logic [2:0] SEL_L = 3'h5;            // Pointer pair low register
  // ****************************************
  // Rotate kinds (opcode bits 4:3)
  // ****************************************
  localparam logic [1:0] KIND_LC = 2'h0;  // Left circular
  localparam logic [1:0] KIND_RC = 2'h1;  // Right circular
  localparam logic [1:0] KIND_LT = 2'h2;  // Left through carry
  localparam logic [1:0] KIND_RT = 2'h3;  // Right through carry
  // ****************************************
  // Flag bit positions
  // ****************************************
  localparam int FLAG_S = 7;   // Sign
  localparam int FLAG_Z = 6;   // Zero
  localparam int FLAG_H = 4;   // Half carry
  localparam int FLAG_PV = 2;  // Parity/overflow
  localparam int FLAG_N = 1;   // Add/subtract
  localparam int FLAG_C = 0;   // Carry
  // ****************************************
  // Clock-state schedule, one clock per state from state 0
  // ****************************************
  localparam logic [4:0] T_ONE = 5'h01;       // Step of the state counter
  localparam logic [4:0] T_REQ0 = 5'h00;      // First byte request
  localparam logic [4:0] T_CAP0 = 5'h02;      // First byte capture
  localparam logic [4:0] T_REQ1 = 5'h04;      // Second byte request
  localparam logic [4:0] T_CAP1 = 5'h06;      // Second byte capture
  localparam logic [4:0] T_REG_LAST = 5'h07;  // Register form: write back, 8 states
  localparam logic [4:0] T_HL_RD = 5'h08;     // Pointer form: read request
  localparam logic [4:0] T_HL_CAP = 5'h0a;    // Pointer form: read capture
  localparam logic [4:0] T_HL_WR = 5'h0c;     // Pointer form: write request
  localparam logic [4:0] T_HL_LAST = 5'h0e;   // Pointer form: 15 states
  localparam logic [4:0] T_D_REQ = 5'h08;     // Indexed: displacement request
  localparam logic [4:0] T_D_CAP = 5'h0a;     // Indexed: displacement capture
  localparam logic [4:0] T_XOP_REQ = 5'h0b;   // Indexed: opcode request
  localparam logic [4:0] T_XOP_CAP = 5'h0d;   // Indexed: opcode capture, address sum
  localparam logic [4:0] T_X_RD = 5'h10;      // Indexed: read request
  localparam logic [4:0] T_X_CAP = 5'h12;     // Indexed: read capture
  localparam logic [4:0] T_X_WR = 5'h14;      // Indexed: write request
  localparam logic [4:0] T_X_LAST = 5'h16;    // Indexed: 23 states
  localparam logic [4:0] LEN_REG = 5'h08;     // Busy length, register form
  localparam logic [4:0] LEN_HL = 5'h0f;      // Busy length, pointer form
  localparam logic [4:0] LEN_X = 5'h17;       // Busy length, indexed form
  // Sequencer phase
  typedef enum logic {PH_IDLE, PH_RUN} phase_t;
endpackage

// >>> hdl/rot_if.sv
// Connection between the sequencer and the rotate datapath
`timescale 1ns/1ps
`default_nettype none
interface rot_if;
  logic [1:0] kind;      // Rotate kind
  logic [7:0] src;       // Operand before rotation
  logic [7:0] flags_in;  // Flags before rotation
  logic [7:0] res;       // Rotated result
  logic [7:0] flags_out; // Flags after rotation
  modport core (output kind, output src, output flags_in, input res, input flags_out);
  modport alu (input kind, input src, input flags_in, output res, output flags_out);
endinterface
`default_nettype wire

// >>> hdl/rotate_alu.sv
// One-bit rotate datapath with condition flag generation
`timescale 1ns/1ps
`default_nettype none
module rotate_alu
  import rot_pkg::*;
(
  rot_if.alu r  // Operand in, result and flags out
);
  // ****************************************
  // Rotation and flags
  // ****************************************
  logic [7:0] res;  // Rotated byte
  logic cout;       // Bit shifted out
  // Select the rotation
  always_comb begin
    res = r.src;
    cout = r.flags_in[FLAG_C];
    case (r.kind)
      KIND_LC: begin  // Old bit 7 to carry and bit 0
        res = {r.src[6:0], r.src[7]};
        cout = r.src[7];
      end
      KIND_LT: begin  // Old bit 7 to carry, old carry to bit 0
        res = {r.src[6:0], r.flags_in[FLAG_C]};
        cout = r.src[7];
      end
      KIND_RC: begin  // Old bit 0 to carry and bit 7
        res = {r.src[0], r.src[7:1]};
        cout = r.src[0];
      end
      KIND_RT: begin  // Old bit 0 to carry, old carry to bit 7
        res = {r.flags_in[FLAG_C], r.src[7:1]};
        cout = r.src[0];
      end
      default: begin
        res = r.src;
        cout = r.flags_in[FLAG_C];
      end
    endcase
  end
  // Build the new flag byte; unlisted bits keep their value
  always_comb begin
    r.res = res;
    r.flags_out = r.flags_in;
    r.flags_out[FLAG_S] = res[7];
    r.flags_out[FLAG_Z] = (res == 8'h00);
    r.flags_out[FLAG_PV] = ~(^res);         // Even parity sets it
    r.flags_out[FLAG_H] = 1'b0;
    r.flags_out[FLAG_N] = 1'b0;
    r.flags_out[FLAG_C] = cout;
  end
endmodule
`default_nettype wire

// >>> hdl/prefixed_rotate_unit.sv
// Sequencer, register file and memory access for the prefixed rotates
`timescale 1ns/1ps
`default_nettype none
module prefixed_rotate_unit
  import rot_pkg::*;
(
  input wire logic clk,               // Processor clock
  input wire logic reset,             // Asynchronous reset, active high
  input wire logic ce,                // Clock enable, freezes all state when low
  input wire logic start,             // Begin an instruction (taken when idle)
  output logic op_req,                // Instruction byte request pulse
  input wire logic [7:0] op_byte,     // Instruction byte, two cycles after request
  output logic mem_rd,                // Data read request pulse
  output logic mem_wr,                // Data write pulse
  output logic [15:0] mem_addr,       // Data address
  output logic [7:0] mem_wdata,       // Data written back
  input wire logic [7:0] mem_rdata,   // Read data, two cycles after request
  input wire logic [15:0] first_index_register,   // First index register value
  input wire logic [15:0] second_index_register,  // Second index register value
  input wire logic load_en,           // Load a working register when idle
  input wire logic [2:0] load_sel,    // Register to load
  input wire logic [7:0] load_val,    // Value to load
  input wire logic flag_load_en,      // Load the flag byte when idle
  input wire logic [7:0] flag_val,    // Flag value to load
  input wire logic [2:0] rd_sel,      // Register to observe
  output logic [7:0] rd_val,          // Observed register, one cycle late
  output logic [7:0] flags,           // Condition flags
  output logic busy,                  // Instruction in progress
  output logic done,                  // Instruction finished pulse
  output logic err                    // Finished on an unsupported byte
);
  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    phase_t ph;              // Sequencer phase
    logic [4:0] t;           // Clock state within the instruction
    logic idx;               // Indexed form
    logic use_iy;            // Second index register chosen
    logic mem;               // Memory operand
    logic [1:0] kind;        // Rotate kind
    logic [2:0] sel;         // Register selector
    logic [7:0] disp;        // Signed displacement
    logic [15:0] addr;       // Operand address
    logic [7:0] data;        // Operand byte
    logic [7:0] src;         // Operand of the last commit
    logic cin;               // Carry before the last commit
    logic [7:0] res;         // Result of the last commit
    logic [7:0][7:0] regs;   // Working registers
    logic [7:0] flags;       // Flag byte
    logic op_req;            // Output copies
    logic mem_rd;
    logic mem_wr;
    logic [15:0] mem_addr;
    logic [7:0] mem_wdata;
    logic busy;
    logic done;
    logic err;
    logic [7:0] rd_val;
    logic [4:0] len;         // Busy clocks so far, read by the checks
  } state_t;
  state_t st_q;  // Registered state
  state_t st_d;  // Next state
  rot_if alu_c ();  // Datapath link
  // True for the 32 rotate opcodes (four kinds, eight selectors) in the bit group
  function automatic logic is_rotate(input logic [7:0] b);
    return b[7:5] == 3'h0;
  endfunction
  // ****************************************
  // Datapath
  // ****************************************
  assign alu_c.kind = st_q.kind;
  assign alu_c.src = st_q.data;
  assign alu_c.flags_in = st_q.flags;
  rotate_alu rotate_alu_inst (
    .r(alu_c)
  );
  // Schedule points that differ between pointer and indexed forms
  logic [4:0] rd_t;    // Read request state
  logic [4:0] cap_t;   // Read capture state
  logic [4:0] wr_t;    // Write request state
  logic [4:0] last_t;  // Final state
  assign rd_t = st_q.idx ? T_X_RD : T_HL_RD;
  assign cap_t = st_q.idx ? T_X_CAP : T_HL_CAP;
  assign wr_t = st_q.idx ? T_X_WR : T_HL_WR;
  assign last_t = st_q.idx ? T_X_LAST : (st_q.mem ? T_HL_LAST : T_REG_LAST);
  // ****************************************
  // Next-state logic
  // ****************************************
  always_comb begin
    st_d = st_q;
    st_d.op_req = 1'b0;
    st_d.mem_rd = 1'b0;
    st_d.mem_wr = 1'b0;
    st_d.done = 1'b0;
    st_d.err = 1'b0;
    st_d.rd_val = st_q.regs[rd_sel];
    st_d.len = st_q.busy ? st_q.len + T_ONE : '0;  // Busy clocks of this instruction
    case (st_q.ph)
      PH_IDLE: begin
        // Side loads only between instructions
        if (load_en) begin
          st_d.regs[load_sel] = load_val;
        end
        if (flag_load_en) begin
          st_d.flags = flag_val;
        end
        if (start) begin  // Request the first byte at state 0
          st_d.ph = PH_RUN;
          st_d.t = T_REQ0;
          st_d.busy = 1'b1;
          st_d.op_req = 1'b1;
          st_d.idx = 1'b0;
          st_d.mem = 1'b0;
        end
      end
      PH_RUN: begin
        st_d.t = st_q.t + T_ONE;
        // Further byte requests
        if (st_q.t == T_REQ1) begin
          st_d.op_req = 1'b1;
        end
        if (st_q.idx && (st_q.t == T_D_REQ || st_q.t == T_XOP_REQ)) begin
          st_d.op_req = 1'b1;
        end
        // First byte: bit prefix or index prefix
        if (st_q.t == T_CAP0) begin
          if (op_byte == OPC_PREFIX_X1 || op_byte == OPC_PREFIX_X2) begin
            st_d.idx = 1'b1;
            st_d.use_iy = (op_byte == OPC_PREFIX_X2);
          end else if (op_byte != OPC_PREFIX_BIT) begin
            st_d.err = 1'b1;
          end
        end
        // Second byte: bit prefix after an index prefix, else the opcode
        if (st_q.t == T_CAP1) begin
          if (st_q.idx) begin
            st_d.err = (op_byte != OPC_PREFIX_BIT);
          end else if (!is_rotate(op_byte)) begin
            st_d.err = 1'b1;
          end else begin  // Register or pointer operand
            st_d.kind = op_byte[4:3];
            st_d.sel = op_byte[2:0];
            st_d.mem = (op_byte[2:0] == SEL_MEM);
            st_d.addr = {st_q.regs[SEL_H], st_q.regs[SEL_L]};
            st_d.data = st_q.regs[op_byte[2:0]];
          end
        end
        // Displacement sits between the prefix and the opcode
        if (st_q.idx && st_q.t == T_D_CAP) begin
          st_d.disp = op_byte;
        end
        // Indexed opcode and address sum
        if (st_q.idx && st_q.t == T_XOP_CAP) begin
          if (!is_rotate(op_byte) || op_byte[2:0] != SEL_MEM) begin
            st_d.err = 1'b1;
          end else begin  // Index plus signed displacement
            st_d.kind = op_byte[4:3];
            st_d.mem = 1'b1;
            st_d.addr = (st_q.use_iy ? second_index_register : first_index_register)
                        + {{8{st_q.disp[7]}}, st_q.disp};
          end
        end
        // Memory read, then write back to the same address
        if (st_q.mem && st_q.t == rd_t) begin
          st_d.mem_rd = 1'b1;
          st_d.mem_addr = st_q.addr;
        end
        if (st_q.mem && st_q.t == cap_t) begin
          st_d.data = mem_rdata;
        end
        if (st_q.mem && st_q.t == wr_t) begin
          st_d.mem_wr = 1'b1;
          st_d.mem_addr = st_q.addr;
          st_d.mem_wdata = alu_c.res;
          st_d.flags = alu_c.flags_out;
          st_d.src = st_q.data;
          st_d.cin = st_q.flags[FLAG_C];
          st_d.res = alu_c.res;
        end
        // Register form commits at its last state
        if (!st_q.mem && !st_q.idx && st_q.t == T_REG_LAST) begin
          st_d.regs[st_q.sel] = alu_c.res;
          st_d.flags = alu_c.flags_out;
          st_d.src = st_q.data;
          st_d.cin = st_q.flags[FLAG_C];
          st_d.res = alu_c.res;
        end
        // Finish on the last state or on a refused byte
        if (st_q.t == last_t || st_d.err) begin
          st_d.ph = PH_IDLE;
          st_d.busy = 1'b0;
          st_d.done = 1'b1;
        end
      end
      default: begin
        st_d.ph = PH_IDLE;
      end
    endcase
  end
  // Register the whole state
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      st_q <= '0;
    end else if (ce) begin
      st_q <= st_d;
    end
  end
  // ****************************************
  // Outputs
  // ****************************************
  assign op_req = st_q.op_req;
  assign mem_rd = st_q.mem_rd;
  assign mem_wr = st_q.mem_wr;
  assign mem_addr = st_q.mem_addr;
  assign mem_wdata = st_q.mem_wdata;
  assign rd_val = st_q.rd_val;
  assign flags = st_q.flags;
  assign busy = st_q.busy;
  assign done = st_q.done;
  assign err = st_q.err;
  // ****************************************
  // Checks
  // ****************************************
  logic ok;  // Completed without a refused byte
  assign ok = st_q.done && !st_q.err;
  a_reg_length: assert property (@(posedge clk iff ce) disable iff (reset)
    ok && !st_q.mem |-> st_q.len == LEN_REG) else $error("register rotate length wrong");
  a_ptr_length: assert property (@(posedge clk iff ce) disable iff (reset)
    ok && st_q.mem && !st_q.idx |-> st_q.len == LEN_HL)
    else $error("pointer rotate length wrong");
  a_idx_length: assert property (@(posedge clk iff ce) disable iff (reset)
    ok && st_q.idx |-> st_q.len == LEN_X) else $error("indexed rotate length wrong");
  a_sign_zero_flags: assert property (@(posedge clk iff ce) disable iff (reset)
    ok |-> st_q.flags[FLAG_S] == st_q.res[7] && st_q.flags[FLAG_Z] == (st_q.res == 8'h00))
    else $error("sign or zero flag wrong");
  a_parity_flag: assert property (@(posedge clk iff ce) disable iff (reset)
    ok |-> st_q.flags[FLAG_PV] == ~(^st_q.res)) else $error("parity flag wrong");
  a_hn_flags_clear: assert property (@(posedge clk iff ce) disable iff (reset)
    ok |-> !st_q.flags[FLAG_H] && !st_q.flags[FLAG_N]) else $error("H or N not cleared");
  a_left_circ_value: assert property (@(posedge clk iff ce) disable iff (reset)
    ok && st_q.kind == KIND_LC |-> st_q.res == {st_q.src[6:0], st_q.src[7]}
    && st_q.flags[FLAG_C] == st_q.src[7]) else $error("left circular wrong");
  a_left_thru_value: assert property (@(posedge clk iff ce) disable iff (reset)
    ok && st_q.kind == KIND_LT |-> st_q.res == {st_q.src[6:0], st_q.cin})
    else $error("left through carry wrong");
  a_left_carry_src: assert property (@(posedge clk iff ce) disable iff (reset)
    ok && !st_q.kind[0] |-> st_q.flags[FLAG_C] == st_q.src[7]) else $error("left carry wrong");
  a_right_circ_value: assert property (@(posedge clk iff ce) disable iff (reset)
    ok && st_q.kind == KIND_RC |-> st_q.res == {st_q.src[0], st_q.src[7:1]}
    && st_q.flags[FLAG_C] == st_q.src[0]) else $error("right circular wrong");
  a_right_thru_value: assert property (@(posedge clk iff ce) disable iff (reset)
    ok && st_q.kind == KIND_RT |-> st_q.res == {st_q.cin, st_q.src[7:1]}
    && st_q.flags[FLAG_C] == st_q.src[0]) else $error("right through carry wrong");
  a_writeback_addr: assert property (@(posedge clk iff ce) disable iff (reset)
    st_q.mem_wr |-> $past(st_q.mem_rd, 4) && $past(st_q.mem_addr, 4) == st_q.mem_addr)
    else $error("write back not to read address");
  c_reg_form: cover property (@(posedge clk iff ce) disable iff (reset)
    ok && !st_q.mem);
  c_ptr_form: cover property (@(posedge clk iff ce) disable iff (reset)
    ok && st_q.mem && !st_q.idx);
  c_idx_form: cover property (@(posedge clk iff ce) disable iff (reset)
    ok && st_q.idx && st_q.use_iy);
  c_refused: cover property (@(posedge clk iff ce) disable iff (reset)
    st_q.done && st_q.err);
endmodule
`default_nettype wire

// >>> test/prefixed_rotate_unit_tb_top.sv
// Self-checking testbench for the prefixed rotate unit
`timescale 1ns/1ps
`default_nettype none
module prefixed_rotate_unit_tb_top;
  import rot_pkg::*;
  // ****************************************
  // Stimulus and observation signals
  // ****************************************
  logic clk = 1'b0; // Processor clock, 4 ns
  logic reset = 1'b1; // Asynchronous reset
  logic ce = 1'b1; // Clock enable, dropped for stalls
  logic start = 1'b0; // Instruction start
  logic load_en = 1'b0; // Working register load
  logic flag_load_en = 1'b0; // Flag byte load
  logic [2:0] load_sel = 3'h0; // Register to load
  logic [7:0] load_val = 8'h00; // Value to load
  logic [7:0] flag_val = 8'h00; // Flags to load
  logic [2:0] rd_sel = 3'h0; // Register to observe
  logic [7:0] op_byte = 8'h00; // Instruction byte
  logic [7:0] mem_rdata = 8'h00; // Memory read data
  logic [15:0] x1 = 16'h0000; // First index value
  logic [15:0] x2 = 16'h0000; // Second index value
  logic op_req, mem_rd, mem_wr, busy, done, err; // Design outputs
  logic [15:0] mem_addr; // Data address
  logic [7:0] mem_wdata, rd_val, flags; // Data, register and flags
  logic [7:0] prog [$]; // Instruction bytes still to hand out
  logic [7:0] mem [bit [15:0]]; // Data memory
  logic [15:0] waddr; // Last written address
  int wcnt; // Number of writes seen
  int fail_count = 0; // Mismatches
  int comparisons = 0; // Comparisons made
  // ****************************************
  // Design under test
  // ****************************************
  prefixed_rotate_unit prefixed_rotate_unit_inst (
    .clk(clk), .reset(reset), .ce(ce), .start(start), .op_req(op_req), .op_byte(op_byte),
    .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .mem_rdata(mem_rdata), .first_index_register(x1), .second_index_register(x2),
    .load_en(load_en), .load_sel(load_sel), .load_val(load_val),
    .flag_load_en(flag_load_en), .flag_val(flag_val), .rd_sel(rd_sel), .rd_val(rd_val),
    .flags(flags), .busy(busy), .done(done), .err(err));
  // Clock generation
  always #2 clk = ~clk;
  // Instruction feed and data memory, answering on the falling edge
  always @(negedge clk) begin
    if (op_req === 1'b1 && prog.size() > 0) op_byte <= prog.pop_front();
    if (mem_rd === 1'b1) mem_rdata <= mem.exists(mem_addr) ? mem[mem_addr] : 8'h5a;
    if (mem_wr === 1'b1) begin
      mem[mem_addr] = mem_wdata;
      waddr = mem_addr;
      wcnt++;
    end
  end
  // ****************************************
  // Helpers
  // ****************************************
  // Compare and count
  task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (e !== g) begin
      fail_count++;
      $display("unexpected %s: expected %h, seen %h", nm, e, g);
    end
  endtask
  // Reference rotate: result in the high byte, flags in the low byte
  function automatic logic [15:0] model(input logic [1:0] k, input logic [7:0] v,
                                        input logic [7:0] f);
    logic [7:0] r;
    logic c;
    case (k)
      KIND_LC: begin r = {v[6:0], v[7]}; c = v[7]; end
      KIND_RC: begin r = {v[0], v[7:1]}; c = v[0]; end
      KIND_LT: begin r = {v[6:0], f[0]}; c = v[7]; end
      default: begin r = {f[0], v[7:1]}; c = v[0]; end
    endcase
    return {r, r[7], r == 8'h00, f[5], 1'b0, f[3], ~^r, 1'b0, c};
  endfunction
  // Load a working register while idle
  task automatic set_reg(input logic [2:0] s, input logic [7:0] v);
    load_en = 1'b1; load_sel = s; load_val = v;
    @(negedge clk);
    load_en = 1'b0;
  endtask
  // Load the flag byte while idle
  task automatic set_flags(input logic [7:0] v);
    flag_load_en = 1'b1; flag_val = v;
    @(negedge clk);
    flag_load_en = 1'b0;
  endtask
  // Observe a working register
  task automatic get_reg(input logic [2:0] s, output logic [7:0] v);
    rd_sel = s;
    @(negedge clk);
    v = rd_val;
  endtask
  // Run one instruction from prog; len 0 means a refusal is expected
  // A stall freezes the clock enable for that many clocks in state 2
  task automatic exec(input int len, input logic exp_err, input int stall);
    int n;
    int b;
    start = 1'b1;
    @(negedge clk);
    start = 1'b0;
    n = 1;
    b = 0;
    while (done !== 1'b1 && n < 60) begin
      if (busy === 1'b1) b++;
      ce = (n < 3 || n >= 3 + stall);
      @(negedge clk);
      n++;
    end
    if (len > 0) check("done cycle", len + 1 + stall, n);
    if (len > 0) check("busy cycles", len + stall, b);
    check("err", {31'h0, exp_err}, {31'h0, err});
    prog.delete();
  endtask
  // Finish the run
  task automatic end_sim();
    $display("comparisons %0d, mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Watchdog
  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    end_sim();
  end
  // ****************************************
  // Tests
  // ****************************************
  initial begin
    logic [7:0] v, f, g, d;
    logic [15:0] e, a;
    repeat (8) @(negedge clk);
    reset = 1'b0;
    // Register forms, every kind and every selector except the memory code 6
    for (int k = 0; k < 4; k++) begin
      for (int s = 0; s < 8; s++) begin
        if (s == 6) continue;
        v = (s == 3) ? 8'h00 : 8'h81 + 8'(s * 19 + k * 64);
        f = 8'h3a | 8'(s & 1);
        set_reg(3'(s), v);
        set_flags(f);
        e = model(2'(k), v, f);
        prog = '{OPC_PREFIX_BIT, {2'b00, 2'(k), 3'(s)}};
        exec(8, 1'b0, 0);
        get_reg(3'(s), g);
        check("register result", e[15:8], g);
        check("register flags", e[7:0], flags);
      end
    end
    $display("test register forms done");
    // Pointer-pair memory forms
    for (int k = 0; k < 4; k++) begin
      v = 8'h88 ^ 8'(k * 85);
      f = 8'h12 | 8'(k & 1);
      set_reg(SEL_H, 8'h28);
      set_reg(SEL_L, 8'h29);
      mem[16'h2829] = v;
      set_flags(f);
      wcnt = 0;
      e = model(2'(k), v, f);
      prog = '{OPC_PREFIX_BIT, {2'b00, 2'(k), SEL_MEM}};
      exec(15, 1'b0, k);
      check("pointer byte", e[15:8], mem[16'h2829]);
      check("pointer write address", 16'h2829, waddr);
      check("pointer writes", 1, wcnt);
      check("pointer flags", e[7:0], flags);
    end
    $display("test pointer forms done");
    // Indexed forms, both prefixes, positive and negative displacement
    for (int i = 0; i < 4; i++) begin
      a = (i < 2) ? 16'h1000 : 16'h0001;
      d = (i < 2) ? 8'h02 : 8'hfe;
      x1 = (i % 2 == 0) ? a : a ^ 16'h0f00;
      x2 = (i % 2 == 1) ? a : a ^ 16'h0f00;
      a = a + {{8{d[7]}}, d};
      v = 8'h88 ^ 8'(i * 51);
      f = 8'h28 | 8'(i >> 1);
      mem[a] = v;
      set_flags(f);
      wcnt = 0;
      e = model(2'(i), v, f);
      prog = '{(i % 2 == 0) ? OPC_PREFIX_X1 : OPC_PREFIX_X2, OPC_PREFIX_BIT, d,
               {2'b00, 2'(i), SEL_MEM}};
      exec(23, 1'b0, 0);
      check("indexed byte", e[15:8], mem[a]);
      check("indexed write address", a, waddr);
      check("indexed writes", 1, wcnt);
      check("indexed flags", e[7:0], flags);
    end
    $display("test indexed forms done");
    // Refused sequences leave flags and memory alone
    for (int i = 0; i < 4; i++) begin
      set_flags(8'hc5);
      wcnt = 0;
      case (i)
        0: prog = '{8'h00};
        1: prog = '{OPC_PREFIX_BIT, 8'h26};
        2: prog = '{OPC_PREFIX_X1, 8'h00};
        default: prog = '{OPC_PREFIX_X2, OPC_PREFIX_BIT, 8'h02, 8'h07};
      endcase
      exec(0, 1'b1, 0);
      check("refused flags", 8'hc5, flags);
      check("refused writes", 0, wcnt);
    end
    $display("test refusals done");
    end_sim();
  end
endmodule
`default_nettype wire
